// ### src/protection_status_and_limit_regs.sv
// Protection flag and current limit configuration registers.
// Assumes the serial bus logic presents a synchronous byte register port.
module protection_status_and_limit_regs
    import prot_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic temp_warning,
    input wire logic power_good,
    input wire logic follow_fault,
    input wire logic overheat,
    input wire logic overcurrent,
    input wire logic undervoltage,
    input wire logic high_output,
    input wire logic phase_error,
    output logic [2:0] load_regulation_slope,
    output logic temperature_compensation_enable,
    output logic [3:0] current_limit_code
);

    // Active-high view of every protection condition, in flag order
    logic [7:0] fault_active;

    // Flags as the host sees them, zero while a condition is active
    logic [7:0] protection_flags_reg;

    // Stored slope field, read back as written
    logic [2:0] slope_field_reg;

    // Stored temperature compensation enable
    logic tcomp_field_reg;

    // Stored raw limit code; may hold a value above the ceiling
    logic [3:0] code_field_reg;

    // Whole configuration byte as the host reads it back
    logic [7:0] current_limit_config;

    // Saturated code from the clamp
    logic [3:0] clamped_code;

    // Decoded register port strobes
    logic limit_wr_hit;
    logic flags_rd_hit;
    logic limit_rd_hit;

    // Read data ahead of its output register
    logic [7:0] reg_rdata_next;

    // Write decode; flags and unmapped places have no write path at all
    assign limit_wr_hit = reg_wr && (reg_addr == LIMIT_ADDR);

    // Read decode; both hits low during a read means an unmapped place
    assign flags_rd_hit = reg_rd && (reg_addr == FLAGS_ADDR);
    assign limit_rd_hit = reg_rd && (reg_addr == LIMIT_ADDR);

    // Condition inputs gathered by flag position, all active high except power_good, which is inverted
    always_comb begin
        fault_active = '0;
        fault_active[TEMP_BIT] = temp_warning;
        fault_active[PGOOD_BIT] = ~power_good; // Power not good is the condition
        fault_active[FOLLOW_BIT] = follow_fault;
        fault_active[HEAT_BIT] = overheat;
        fault_active[OCUR_BIT] = overcurrent;
        fault_active[UVOLT_BIT] = undervoltage;
        fault_active[HVOLT_BIT] = high_output;
        fault_active[PHASE_BIT] = phase_error;
    end

    // One flag flip-flop per bit; no latching, so a cleared condition
    // shows as one again on the next edge without any host action
    for (genvar k = 0; k < $bits(protection_flags_reg); k++) begin : gen_flag
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                protection_flags_reg[k] <= FLAGS_RESET[k];
            end else begin
                protection_flags_reg[k] <= ~fault_active[k];
            end
        end
    end

    // Slope field of the configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slope_field_reg <= LIMIT_RESET[SLOPE_MSB:SLOPE_LSB];
        end else if (limit_wr_hit) begin
            slope_field_reg <= reg_wdata[SLOPE_MSB:SLOPE_LSB];
        end
    end

    // Temperature compensation enable; stored only, its effect lies elsewhere
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tcomp_field_reg <= LIMIT_RESET[TCOMP_BIT];
        end else if (limit_wr_hit) begin
            tcomp_field_reg <= reg_wdata[TCOMP_BIT];
        end
    end

    // Raw limit code; kept unclamped so the host reads back what it wrote
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            code_field_reg <= LIMIT_RESET[CODE_MSB:CODE_LSB];
        end else if (limit_wr_hit) begin
            code_field_reg <= reg_wdata[CODE_MSB:CODE_LSB];
        end
    end

    // Readback byte assembled from the stored fields
    assign current_limit_config = {slope_field_reg, tcomp_field_reg, code_field_reg};

    // Only the applied value saturates, never the stored one
    limit_clamp u_clamp (
        .code_in(code_field_reg),
        .code_out(clamped_code)
    );

    // Applied slope; one extra stage keeps the output a plain flip-flop
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_regulation_slope <= LIMIT_RESET[SLOPE_MSB:SLOPE_LSB];
        end else begin
            load_regulation_slope <= slope_field_reg;
        end
    end

    // Applied temperature compensation enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            temperature_compensation_enable <= LIMIT_RESET[TCOMP_BIT];
        end else begin
            temperature_compensation_enable <= tcomp_field_reg;
        end
    end

    // Applied limit code, always at or below the ceiling
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            current_limit_code <= LIMIT_RESET[CODE_MSB:CODE_LSB];
        end else begin
            current_limit_code <= clamped_code;
        end
    end

    // Read multiplexer; data holds between reads, unmapped reads give zero
    always_comb begin
        reg_rdata_next = reg_rdata;
        if (flags_rd_hit) begin
            reg_rdata_next = protection_flags_reg;
        end else if (limit_rd_hit) begin
            reg_rdata_next = current_limit_config;
        end else if (reg_rd) begin
            reg_rdata_next = 8'h00; // Unmapped place
        end
    end

    // Read data register; a read changes no other state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rdata_next;
        end
    end
endmodule : protection_status_and_limit_regs

// ### src/prot_regs_pkg.sv
// Package of register offsets, field layouts and reset values for the protection register bank.
// Assumes an internal byte-wide register port from the serial interface logic.
package prot_regs_pkg;
    localparam logic [7:0] FLAGS_ADDR = 8'h00;
    localparam logic [7:0] LIMIT_ADDR = 8'h01;
    localparam logic [7:0] FLAGS_RESET = 8'hbf;
    localparam logic [7:0] LIMIT_RESET = 8'h1b;
    localparam logic [3:0] LIMIT_CODE_MAX = 4'hb;
    localparam int TEMP_BIT = 7;
    localparam int PGOOD_BIT = 6;
    localparam int FOLLOW_BIT = 5;
    localparam int HEAT_BIT = 4;
    localparam int OCUR_BIT = 3;
    localparam int UVOLT_BIT = 2;
    localparam int HVOLT_BIT = 1;
    localparam int PHASE_BIT = 0;
    localparam int SLOPE_MSB = 7;
    localparam int SLOPE_LSB = 5;
    localparam int TCOMP_BIT = 4;
    localparam int CODE_MSB = 3;
    localparam int CODE_LSB = 0;
endpackage : prot_regs_pkg

// ### src/limit_clamp.sv
// Saturating clamp for the current limit code.
// Assumes a four-bit code; pure combinational.
module limit_clamp
    import prot_regs_pkg::*;
(
    input wire logic [3:0] code_in,
    output logic [3:0] code_out
);
    // Codes above the maximum saturate
    always_comb begin
        code_out = (code_in > LIMIT_CODE_MAX) ? LIMIT_CODE_MAX : code_in;
    end
endmodule : limit_clamp

// ### sim/prot_regs_sva.sv
// Port assertions for the protection bank.
// Assumes one clock; bound to the top module.
module prot_regs_sva (input wire logic core_clk, rst, reg_wr, reg_rd, temperature_compensation_enable,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, input wire logic [2:0] load_regulation_slope,
    input wire logic [3:0] current_limit_code);
    logic [7:0] w1, w2;
    wire logic cw = reg_wr && reg_addr == 8'h01;
    wire logic [7:0] o = {load_regulation_slope, temperature_compensation_enable, current_limit_code};
    // Write data delayed two edges to meet the applied outputs
    always_ff @(posedge core_clk) {w2, w1} <= {w1, reg_wdata};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence wr; cw ##1 !cw; endsequence
    chk_slope_apply: assert property (wr |=> o[7:5] == w2[7:5]) else $error("slope");
    chk_tce_apply: assert property (wr |=> o[4] == w2[4]) else $error("tce");
    chk_code_apply: assert property (wr |=> o[3:0] == (w2[3:0] > 4'hb ? 4'hb : w2[3:0])) else $error("code");
    chk_code_max: assert property (o[3:0] <= 4'hb) else $error("code max");
    chk_out_hold: assert property (!cw [*2] |=> $stable(o)) else $error("hold");
    chk_cfg_read: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata[7:4] == o[7:4]) else $error("read");
    chk_unmapped_read: assert property (reg_rd && reg_addr > 8'h01 |=> reg_rdata == 8'h00) else $error("unmapped");
    chk_rdata_hold: assert property ($changed(reg_rdata) |-> $past(reg_rd)) else $error("rdata");
endmodule : prot_regs_sva
bind protection_status_and_limit_regs prot_regs_sva prot_regs_sva_i(.*);

// ### sim/host_model.sv
// Register host model.
// Assumes one access at a time, from a falling edge.
module host_model (input wire logic core_clk, output logic reg_wr = 1'b0, reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00);
    timeunit 1ns;
    timeprecision 1ns;
    // One strobe edge; data inverted after so stale values never match
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge core_clk) {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
        @(negedge core_clk) {reg_wdata, reg_wr, reg_rd} = {~d, 2'b00};
    endtask : acc
endmodule : host_model

// ### sim/tb.sv
// Bench for the protection bank.
// Assumes host_model drives the register port.
module tb;
    import prot_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst = 1, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, f = 8'h00, d, c = LIMIT_RESET;
    wire logic [7:0] o;
    int n_errors = 0, n_compared = 0, seed = 5;
    always #5 core_clk = ~core_clk;
    host_model host_model_i(.*);
    protection_status_and_limit_regs protection_status_and_limit_regs_i(.*, .temp_warning(f[7]), .power_good(f[6]),
        .follow_fault(f[5]), .overheat(f[4]), .overcurrent(f[3]), .undervoltage(f[2]), .high_output(f[1]),
        .phase_error(f[0]), .load_regulation_slope(o[7:5]), .temperature_compensation_enable(o[4]),
        .current_limit_code(o[3:0]));
    task automatic ck(input string s, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask : ck
    // Applied code after saturation at the documented ceiling
    function automatic logic [3:0] exp_code(input logic [3:0] raw);
        return (raw > LIMIT_CODE_MAX) ? LIMIT_CODE_MAX : raw;
    endfunction : exp_code
    task automatic close_out;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // Even passes write the read-only flags and read an unmapped place
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 0;
        for (int i = 0; i < 24; i++) begin
            f = 8'($random(seed));
            d = i < 4 ? 8'h5a + 8'(i) : 8'($random(seed));
            host_model_i.acc(1'b0, FLAGS_ADDR, 8'h00);
            ck("flags", f ^ 8'hbf, reg_rdata);
            host_model_i.acc(1'b1, i[0] ? LIMIT_ADDR : FLAGS_ADDR, d);
            c = i[0] ? d : c;
            host_model_i.acc(1'b0, i[0] ? LIMIT_ADDR : 8'h80 | 8'(i), 8'h00);
            ck("readback", i[0] ? c : 8'h00, reg_rdata);
            ck("outputs", {c[7:4], exp_code(c[3:0])}, o);
        end
        close_out();
    end
endmodule : tb
